/* shared/vctgo_regs.svh */
`ifndef VCTGO_REGS_SVH
`define VCTGO_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define VCTGO_OFF_DELAY   8'h05
`define VCTGO_OFF_LENGTH  8'h06
`define VCTGO_OFF_GAIN_R  8'h08
`define VCTGO_OFF_OFFS_R  8'h0b
`define VCTGO_OFF_CFG     8'h0f
`define VCTGO_OFF_LEVEL   8'h10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define VCTGO_CFG_POL_BIT  0
`define VCTGO_CFG_EXT_BIT  1
`define VCTGO_CFG_LIVE_BIT 7

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define VCTGO_RST_DELAY   8'h09
`define VCTGO_RST_LENGTH  8'h14
`define VCTGO_RST_GAIN    8'h80
`define VCTGO_RST_OFFS    7'h40
`define VCTGO_CODE_GND    8'h00
`define VCTGO_CODE_MID    8'h80
`define VCTGO_BITS_BYTE   4'd8
`define VCTGO_BITS_ACK    4'd9

`endif

/* shared/vctgo_pkg.sv */
package vctgo_pkg;

  typedef enum logic [4:0] {
    I_IDLE = 5'b00001,
    I_DEV  = 5'b00010,
    I_SUB  = 5'b00100,
    I_WR   = 5'b01000,
    I_RD   = 5'b10000
  } vctgo_i2c_t;

  typedef enum logic [2:0] {
    C_IDLE = 3'b001,
    C_WAIT = 3'b010,
    C_ON   = 3'b100
  } vctgo_phase_t;

  typedef struct packed {
    logic [7:0] gain;
    logic [6:0] offs;
  } vctgo_chan_t;

  typedef struct packed {
    vctgo_i2c_t         st;
    logic [3:0]         bcnt;
    logic [7:0]         sh;
    logic [7:0]         ptr;
    logic               rw;
    logic               nack;
    logic               sda_oe;
    logic               scl_p;
    logic               sda_p;
    vctgo_phase_t       ph;
    logic [7:0]         cnt;
    logic               hs_p;
    logic               clamp;
    logic [7:0]         delay;
    logic [7:0]         length;
    logic               ext;
    logic               pol;
    logic [2:0]         mid;
    vctgo_chan_t [2:0]  chan;
  } vctgo_state_t;

endpackage

/* rtl/vctgo_top.sv */
`timescale 1ns/1ps
`include "vctgo_regs.svh"
// How it works
// - Config bit set: clamp window follows the external strobe pin.
// - A polarity bit decides which strobe level means clamp.
// - Internal mode: window starts delay pixel clocks after sync trailing edge.
// - Internal window stays on for the programmed length in pixel clocks.
// - Ground-clamped channel gets target code 0x00 during the window.
// - Midscale-clamped channel gets target code 0x80 during the window.
// - Clamp_level_select bits 2:0 pick midscale or ground per channel.
// - Each channel has its own 8-bit full-scale gain.
// - Each channel has its own 7-bit offset setting.
module vctgo_top #(
  parameter logic [6:0] DEV_ADDR = 7'h4c // Arbitrary value
) (
  input  wire logic                             clk,
  input  wire logic                             reset_n,
  input  wire logic                             scl,
  input  wire logic                             sda_i,
  output logic                                  sda_o,
  output logic                                  sda_oe,
  input  wire logic                             addr_sel,
  input  wire logic                             hsync,
  input  wire logic                             clamp_pin,
  output logic                                  clamp_active,
  output logic [2:0]                            midscale_sel,
  output logic [2:0][7:0]                       clamp_code,
  output vctgo_pkg::vctgo_chan_t [2:0]          chan_cfg
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam vctgo_pkg::vctgo_state_t RST = '{
    st: vctgo_pkg::I_IDLE, bcnt: 4'h0, sh: 8'h00, ptr: 8'h00, rw: 1'b0,
    nack: 1'b0, sda_oe: 1'b0, scl_p: 1'b1, sda_p: 1'b1,
    ph: vctgo_pkg::C_IDLE, cnt: 8'h00, hs_p: 1'b0, clamp: 1'b0,
    delay: `VCTGO_RST_DELAY, length: `VCTGO_RST_LENGTH,
    ext: 1'b0, pol: 1'b1, mid: 3'h0,
    chan: {3{`VCTGO_RST_GAIN, `VCTGO_RST_OFFS}}
  };

  vctgo_pkg::vctgo_state_t s_q;
  vctgo_pkg::vctgo_state_t s_d;
  logic                    trig;
  logic                    wr_en;

  function automatic logic [7:0] rd_reg(input logic [7:0] a,
                                        input vctgo_pkg::vctgo_state_t s);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      `VCTGO_OFF_DELAY:  v = s.delay;
      `VCTGO_OFF_LENGTH: v = s.length;
      `VCTGO_OFF_LEVEL:  v = {5'h00, s.mid};
      `VCTGO_OFF_CFG:
      begin
        v[`VCTGO_CFG_POL_BIT]  = s.pol;
        v[`VCTGO_CFG_EXT_BIT]  = s.ext;
        v[`VCTGO_CFG_LIVE_BIT] = s.clamp;
      end
      default: v = 8'h00;
    endcase
    for (int i = 0; i < 3; i++)
    begin
      if (a == `VCTGO_OFF_GAIN_R + 8'(i))
        v = s.chan[i].gain;
      if (a == `VCTGO_OFF_OFFS_R + 8'(i))
        v = {1'b0, s.chan[i].offs};
    end
    return v;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic       start;
    logic       stop;
    logic       rise;
    logic       fall;
    logic       load;
    logic [7:0] rdat;
    s_d   = s_q;
    wr_en = 1'b0;
    load  = 1'b0;
    start = scl && s_q.scl_p && s_q.sda_p && !sda_i;
    stop  = scl && s_q.scl_p && !s_q.sda_p && sda_i;
    rise  = scl && !s_q.scl_p;
    fall  = !scl && s_q.scl_p;
    rdat  = rd_reg(s_q.ptr, s_q);
    s_d.scl_p = scl;
    s_d.sda_p = sda_i;
    s_d.hs_p  = hsync;
    // Serial port
    if (start)
    begin
      s_d.st     = vctgo_pkg::I_DEV;
      s_d.bcnt   = 4'h0;
      s_d.sda_oe = 1'b0;
    end
    else if (stop)
    begin
      s_d.st     = vctgo_pkg::I_IDLE;
      s_d.sda_oe = 1'b0;
    end
    else if (s_q.st != vctgo_pkg::I_IDLE)
    begin
      if (rise && s_q.bcnt <= `VCTGO_BITS_BYTE)
      begin
        s_d.bcnt = s_q.bcnt + 4'h1;
        if (s_q.bcnt == `VCTGO_BITS_BYTE)
          s_d.nack = sda_i;
        else if (s_q.st != vctgo_pkg::I_RD)
          s_d.sh = {s_q.sh[6:0], sda_i};
      end
      else if (fall && s_q.bcnt == `VCTGO_BITS_BYTE)
      begin
        unique case (s_q.st)
          vctgo_pkg::I_DEV:
          begin
            if (s_q.sh[7:1] == {DEV_ADDR[6:1], addr_sel})
            begin
              s_d.sda_oe = 1'b1;
              s_d.rw     = s_q.sh[0];
            end
            else
              s_d.st = vctgo_pkg::I_IDLE;
          end
          vctgo_pkg::I_SUB:
          begin
            s_d.ptr    = s_q.sh;
            s_d.sda_oe = 1'b1;
          end
          vctgo_pkg::I_WR:
          begin
            wr_en      = 1'b1;
            s_d.ptr    = s_q.ptr + 8'h01;
            s_d.sda_oe = 1'b1;
          end
          vctgo_pkg::I_RD:   s_d.sda_oe = 1'b0;
          vctgo_pkg::I_IDLE: s_d.sda_oe = 1'b0;
        endcase
      end
      else if (fall && s_q.bcnt == `VCTGO_BITS_ACK)
      begin
        s_d.bcnt   = 4'h0;
        s_d.sda_oe = 1'b0;
        unique case (s_q.st)
          vctgo_pkg::I_DEV:
          begin
            load = s_q.rw;
            if (!s_q.rw)
              s_d.st = vctgo_pkg::I_SUB;
          end
          vctgo_pkg::I_SUB:  s_d.st = vctgo_pkg::I_WR;
          vctgo_pkg::I_WR:   s_d.st = vctgo_pkg::I_WR;
          vctgo_pkg::I_RD:
          begin
            load = !s_q.nack;
            if (s_q.nack)
              s_d.st = vctgo_pkg::I_IDLE;
          end
          vctgo_pkg::I_IDLE: s_d.st = vctgo_pkg::I_IDLE;
        endcase
        if (load)
        begin
          s_d.st     = vctgo_pkg::I_RD;
          s_d.sh     = rdat;
          s_d.ptr    = s_q.ptr + 8'h01;
          s_d.sda_oe = !rdat[7];
        end
      end
      else if (fall && s_q.st == vctgo_pkg::I_RD)
      begin
        s_d.sh     = {s_q.sh[6:0], 1'b0};
        s_d.sda_oe = !s_q.sh[6];
      end
    end
    // Register writes
    if (wr_en)
    begin
      case (s_q.ptr)
        `VCTGO_OFF_DELAY:  s_d.delay  = s_q.sh;
        `VCTGO_OFF_LENGTH: s_d.length = s_q.sh;
        `VCTGO_OFF_LEVEL:  s_d.mid    = s_q.sh[2:0];
        `VCTGO_OFF_CFG:
        begin
          s_d.ext = s_q.sh[`VCTGO_CFG_EXT_BIT];
          s_d.pol = s_q.sh[`VCTGO_CFG_POL_BIT];
        end
        default: s_d.ext = s_q.ext;
      endcase
      for (int i = 0; i < 3; i++)
      begin
        if (s_q.ptr == `VCTGO_OFF_GAIN_R + 8'(i))
          s_d.chan[i].gain = s_q.sh;
        if (s_q.ptr == `VCTGO_OFF_OFFS_R + 8'(i))
          s_d.chan[i].offs = s_q.sh[6:0];
      end
    end
    // Clamp window timing
    trig = s_q.hs_p && !hsync;
    if (trig)
    begin
      s_d.ph  = (s_q.delay != 8'h00) ? vctgo_pkg::C_WAIT :
                (s_q.length != 8'h00) ? vctgo_pkg::C_ON : vctgo_pkg::C_IDLE;
      s_d.cnt = (s_q.delay != 8'h00) ? s_q.delay : s_q.length;
    end
    else
    begin
      unique case (s_q.ph)
        vctgo_pkg::C_WAIT:
        begin
          s_d.cnt = s_q.cnt - 8'h01;
          if (s_q.cnt == 8'h01)
          begin
            s_d.ph  = (s_q.length != 8'h00) ? vctgo_pkg::C_ON : vctgo_pkg::C_IDLE;
            s_d.cnt = s_q.length;
          end
        end
        vctgo_pkg::C_ON:
        begin
          s_d.cnt = s_q.cnt - 8'h01;
          if (s_q.cnt == 8'h01)
            s_d.ph = vctgo_pkg::C_IDLE;
        end
        vctgo_pkg::C_IDLE: s_d.cnt = s_q.cnt;
      endcase
    end
    s_d.clamp = s_q.ext ? (clamp_pin == s_q.pol)
                        : (s_d.ph == vctgo_pkg::C_ON);
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      s_q <= RST;
    else
      s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign sda_o        = 1'b0;
  assign sda_oe       = s_q.sda_oe;
  assign clamp_active = s_q.clamp;
  assign midscale_sel = s_q.mid;
  assign chan_cfg     = s_q.chan;

  for (genvar g = 0; g < 3; g++)
  begin : g_code
    assign clamp_code[g] = s_q.mid[g] ? `VCTGO_CODE_MID : `VCTGO_CODE_GND;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_ext_on;
    @(posedge clk) disable iff (!reset_n)
    s_q.ext && clamp_pin == s_q.pol |=> clamp_active;
  endproperty
  a_ext_on: assert property (p_ext_on) else $error("strobe not followed");

  property p_ext_off;
    @(posedge clk) disable iff (!reset_n)
    s_q.ext && clamp_pin != s_q.pol |=> !clamp_active;
  endproperty
  a_ext_off: assert property (p_ext_off) else $error("polarity ignored");

  property p_delay;
    @(posedge clk) disable iff (!reset_n)
    trig && !s_q.ext && s_q.delay == 8'h02 && s_q.length != 8'h00
      |=> !clamp_active [*2] ##1 clamp_active;
  endproperty
  a_delay: assert property (p_delay) else $error("window start wrong");

  property p_length;
    @(posedge clk) disable iff (!reset_n)
    !s_q.ext && s_q.ph == vctgo_pkg::C_WAIT && s_q.cnt == 8'h01 && !trig
      && s_q.length == 8'h03 ##1 !trig [*4]
      |-> $past(clamp_active, 3) && $past(clamp_active, 1) && !clamp_active;
  endproperty
  a_length: assert property (p_length) else $error("window length wrong");

  property p_restart;
    @(posedge clk) disable iff (!reset_n)
    trig && s_q.delay != 8'h00
      |=> s_q.ph == vctgo_pkg::C_WAIT && s_q.cnt == $past(s_q.delay);
  endproperty
  a_restart: assert property (p_restart) else $error("no restart on sync");

  property p_gnd;
    @(posedge clk) disable iff (!reset_n)
    !midscale_sel[0] |-> clamp_code[0] == `VCTGO_CODE_GND;
  endproperty
  a_gnd: assert property (p_gnd) else $error("ground code wrong");

  property p_mid;
    @(posedge clk) disable iff (!reset_n)
    midscale_sel[1] |-> clamp_code[1] == `VCTGO_CODE_MID;
  endproperty
  a_mid: assert property (p_mid) else $error("midscale code wrong");

  property p_level;
    @(posedge clk) disable iff (!reset_n)
    wr_en && s_q.ptr == `VCTGO_OFF_LEVEL |=> midscale_sel == $past(s_q.sh[2:0]);
  endproperty
  a_level: assert property (p_level) else $error("level select not stored");

  property p_gain;
    @(posedge clk) disable iff (!reset_n)
    wr_en && s_q.ptr == `VCTGO_OFF_GAIN_R + 8'h01 |=> chan_cfg[1].gain == $past(s_q.sh);
  endproperty
  a_gain: assert property (p_gain) else $error("gain not stored");

  property p_offs;
    @(posedge clk) disable iff (!reset_n)
    wr_en && s_q.ptr == `VCTGO_OFF_OFFS_R + 8'h02
      |=> chan_cfg[2].offs == $past(s_q.sh[6:0]);
  endproperty
  a_offs: assert property (p_offs) else $error("offset not stored");

  c_int_win: cover property (@(posedge clk) !s_q.ext && $rose(clamp_active));
  c_ext_win: cover property (@(posedge clk) s_q.ext && $rose(clamp_active));
  c_write:   cover property (@(posedge clk) wr_en);
  c_read:    cover property (@(posedge clk) s_q.st == vctgo_pkg::I_RD && s_q.bcnt == 4'h8);

endmodule

/* tb/vctgo_host_model.sv */
`timescale 1ns/1ps
module vctgo_host_model (
  input  wire logic       clk,
  input  wire logic       sda_i,
  input  wire logic [6:0] dev,
  output logic            scl,
  output logic            sda_h,
  output logic            hsync,
  output logic            clamp_pin
);
  // ----------------------------------------------------------------
  // Serial host, driven on falling clock edges
  // ----------------------------------------------------------------
  initial
  begin
    scl = 1'b1;
    sda_h = 1'b1;
    hsync = 1'b0;
    clamp_pin = 1'b0;
  end
  task automatic hold();
    repeat (4) @(negedge clk);
  endtask
  task automatic start();
    sda_h = 1'b1;
    hold();
    scl = 1'b1;
    hold();
    sda_h = 1'b0;
    hold();
    scl = 1'b0;
    hold();
  endtask
  task automatic stop();
    sda_h = 1'b0;
    hold();
    scl = 1'b1;
    hold();
    sda_h = 1'b1;
    hold();
  endtask
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--)
    begin
      sda_h = tx[i];
      hold();
      scl = 1'b1;
      hold();
      rx[i] = sda_i;
      scl = 1'b0;
      hold();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [8:0] r;
    start();
    xfer({dev, 1'b0, 1'b1}, r);
    ok = ~r[0];
    xfer({a, 1'b1}, r);
    ok = ok & ~r[0];
    xfer({d, 1'b1}, r);
    ok = ok & ~r[0];
    stop();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic [8:0] r;
    start();
    xfer({dev, 1'b0, 1'b1}, r);
    xfer({a, 1'b1}, r);
    start();
    xfer({dev, 1'b1, 1'b1}, r);
    xfer(9'h1ff, r);
    d = r[8:1];
    stop();
  endtask
  // ----------------------------------------------------------------
  // Line sync and strobe source
  // ----------------------------------------------------------------
  task automatic line(input int w);
    @(negedge clk);
    hsync = 1'b1;
    repeat (w) @(negedge clk);
    hsync = 1'b0;
  endtask
  task automatic strobe(input logic lvl);
    @(negedge clk);
    clamp_pin = lvl;
  endtask
endmodule

/* tb/video_clamp_timing_gain_offset_tb.sv */
`timescale 1ns/1ps
`include "vctgo_regs.svh"
module video_clamp_timing_gain_offset_tb;
  logic                        clk = 1'b0;
  logic                        reset_n = 1'b0;
  logic                        addr_sel = 1'b0;
  logic                        scl;
  logic                        sda_h;
  logic                        hsync;
  logic                        clamp_pin;
  logic                        sda_o;
  logic                        sda_oe;
  logic                        clamp_active;
  logic [2:0]                  midscale_sel;
  logic [2:0][7:0]             clamp_code;
  vctgo_pkg::vctgo_chan_t [2:0] chan_cfg;
  logic                        sda_w;
  logic [31:0]                 seed = 32'h2553;
  int                          miscompares = 0;
  int                          n_tests = 0;
  int                          cyc = 0;
  logic [7:0]                  v;
  logic [7:0]                  g[3];
  logic [7:0]                  o[3];
  logic                        ok;
  assign sda_w = sda_h & ~(sda_oe & ~sda_o);
  always #12.5 clk = ~clk;
  vctgo_top dut_u (.clk(clk), .reset_n(reset_n), .scl(scl), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe(sda_oe), .addr_sel(addr_sel), .hsync(hsync), .clamp_pin(clamp_pin),
    .clamp_active(clamp_active), .midscale_sel(midscale_sel), .clamp_code(clamp_code),
    .chan_cfg(chan_cfg));
  vctgo_host_model partner_u (.clk(clk), .sda_i(sda_w), .dev(7'h4c), .scl(scl),
    .sda_h(sda_h), .hsync(hsync), .clamp_pin(clamp_pin));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("Checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic win(input int d, input int l);
    partner_u.line(3);
    @(posedge clk);
    for (int k = 1; k <= d + l + 4; k++)
    begin
      @(posedge clk);
      #1;
      chk(clamp_active, (k >= d && k < d + l), "window");
    end
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      miscompares++;
      finish_test();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (16) @(negedge clk);
    reset_n = 1'b1;
    partner_u.rd(`VCTGO_OFF_DELAY, v);
    chk(v, 8'h09, "delay reset");
    partner_u.rd(`VCTGO_OFF_LENGTH, v);
    chk(v, 8'h14, "length reset");
    partner_u.rd(8'h20, v);
    chk(v, 8'h00, "unmapped read");
    chk(chan_cfg[1], {8'h80, 7'h40}, "chan reset");
    for (int s = 0; s < 8; s++)
    begin
      partner_u.wr(`VCTGO_OFF_LEVEL, s[7:0], ok);
      chk(ok, 1'b1, "write ack");
      chk(midscale_sel, s[2:0], "level select");
      for (int c = 0; c < 3; c++)
        chk(clamp_code[c], s[c] ? 8'h80 : 8'h00, "clamp code");
      partner_u.rd(`VCTGO_OFF_LEVEL, v);
      chk(v[2:0], s[2:0], "level readback");
    end
    for (int c = 0; c < 3; c++)
    begin
      g[c] = 8'(rnd());
      o[c] = 8'(rnd());
      partner_u.wr(`VCTGO_OFF_GAIN_R + c[7:0], g[c], ok);
      partner_u.wr(`VCTGO_OFF_OFFS_R + c[7:0], o[c], ok);
    end
    for (int c = 0; c < 3; c++)
      chk(chan_cfg[c], {g[c], o[c][6:0]}, "gain offset");
    addr_sel = 1'b1;
    partner_u.wr(`VCTGO_OFF_LEVEL, 8'h02, ok);
    chk(ok, 1'b0, "foreign address ack");
    chk(midscale_sel, 3'b111, "foreign address write");
    addr_sel = 1'b0;
    partner_u.wr(`VCTGO_OFF_DELAY, 8'h09, ok);
    partner_u.wr(`VCTGO_OFF_LENGTH, 8'h14, ok);
    win(9, 20);
    for (int n = 0; n < 4; n++)
    begin
      g[0] = (n == 0) ? 8'd2 : 8'(8'd1 + rnd() % 15);
      g[1] = (n == 0) ? 8'd3 : (n == 3) ? 8'd0 : 8'(8'd1 + rnd() % 15);
      partner_u.wr(`VCTGO_OFF_DELAY, g[0], ok);
      partner_u.wr(`VCTGO_OFF_LENGTH, g[1], ok);
      win(g[0], g[1]);
    end
    partner_u.wr(`VCTGO_OFF_LENGTH, 8'd6, ok);
    partner_u.line(2);
    repeat (g[0]) @(negedge clk);
    win(g[0], 6);
    for (int p = 0; p < 2; p++)
    begin
      partner_u.wr(`VCTGO_OFF_CFG, {6'h00, 1'b1, p[0]}, ok);
      for (int n = 0; n < 6; n++)
      begin
        v = 8'(rnd());
        partner_u.strobe(v[0]);
        repeat (3) @(negedge clk);
        chk(clamp_active, v[0] == p[0], "external strobe");
      end
    end
    @(negedge clk);
    reset_n = 1'b0;
    repeat (2) @(negedge clk);
    chk(midscale_sel, 3'b000, "level after reset");
    chk(chan_cfg[0], {8'h80, 7'h40}, "chan after reset");
    chk(clamp_active, 1'b0, "clamp after reset");
    reset_n = 1'b1;
    partner_u.rd(`VCTGO_OFF_CFG, v);
    chk(v, 8'h01, "config after reset");
    finish_test();
  end
endmodule
